/* src/serdes7_defines.vh */
// Constants for the 7:1 forwarded-clock serializer and 1:7 deserializer slice.
// Assumes core_clk runs at the serial bit rate, one lane bit per cycle.
`ifndef SERDES7_DEFINES_VH
`define SERDES7_DEFINES_VH

// ==========================================================================
// Symbol framing
`define SLOT_LAST     3'h6
`define SLOT_IDLE     3'h7
`define FWD_HIGH_SLOTS 3'h4
`define LANES         4
`define SYM_BITS      7
`define WORD_BITS     28
`define BAL_BITS      6
`define BAL_HALF      3'h3

// ==========================================================================
// Receive phase dial and FIFO
`define TAP_MAX       3'h7
`define FIFO_AW       4
`define FIFO_DEPTH    16
`define FIFO_QUARTER  5'h04
`define FIFO_HALF     5'h08
`define FIFO_3QUARTER 5'h0c
`define FIFO_FULL     5'h10

`endif

/* src/serdes_7to1_forwarded_clock.v */
// Four-lane 7:1 serializer with forwarded framing clock, and matching
// 1:7 deserializer that frames on the incoming forwarded clock into a FIFO.
// Assumes core_clk is the serial bit clock: each cycle carries one bit per
// lane, i.e. one edge of the x3.5 DDR clock; seven cycles are one word.
//
// How it works
// RULE1: one 28-bit word per word period, four lanes
// RULE2: bit clock drives data, word tick drives fwd clock
// RULE3: forwarded clock period equals one seven-bit symbol
// RULE4: first nibble starts on forwarded clock rise
// RULE5: balanced mode sends 24 payload bits
// RULE6: more ones gives zero, more zeros one
// RULE7: equal ones and zeros gives zero
// RULE8: slice replicates side by side, shared clock
// RULE9: capture four lanes into 28-bit FIFO words
// RULE10: forwarded clock samples and frames the data; here core_clk samples and the forwarded clock only frames
// RULE11: sampling point shifted into the data eye; here rx_shift_tap shifts whole bits only and eye centring stays at the board
// RULE12: received bits keep transmitter bit pattern
// RULE13: integrator computes shift from period and setup; there is no integrator here, the tap comes from rx_shift_const or steps
// RULE14: shift setting is shift over period times 256; here rx_shift_tap counts whole bits, 0 to 7
// RULE15: constant or variable shift by mode setting
// RULE16: synthesized clock limit lies outside this slice
// RULE17: lane rate up to 640 Mb/s
// RULE18: receiver slices combine for wider links
// RULE19: two bits per sampling clock per lane; here core_clk samples one bit per lane per cycle
// RULE20: FIFO quarter, half and three-quarter flags
// RULE21: one word per forwarded period once aligned
`timescale 1ns/1ps
`include "serdes7_defines.vh"
`default_nettype none

module serdes_7to1_forwarded_clock (
   input  wire        core_clk,
   input  wire        rstn,
   input  wire [27:0] tx_word,
   input  wire        tx_balance_en,
   output wire        tx_word_take,
   output reg  [3:0]  tx_lane,
   output reg         tx_fwd_clk,
   input  wire [3:0]  rx_lane,
   input  wire        rx_fwd_clk,
   input  wire        rx_shift_mode,
   input  wire [2:0]  rx_shift_const,
   input  wire        rx_shift_step,
   input  wire        rx_shift_up,
   output reg  [2:0]  rx_shift_tap,
   output reg         rx_aligned,
   input  wire        rx_rd_en,
   output reg  [27:0] rx_rd_data,
   output reg         rx_rd_valid,
   output wire        rx_empty,
   output wire        rx_full,
   output wire        rx_quarter,
   output wire        rx_half,
   output wire        rx_three_quarter,
   output reg         rx_overflow
);

   // ======================================================================
   // Transmit framing
   reg  [2:0]  tx_slot;
   reg  [27:0] tx_hold;
   wire [27:0] tx_fmt;
   wire [2:0]  next_tx_slot;
   reg         tx_run;
   integer     tl;

   // RULE1: word taken per period
   assign tx_word_take = (tx_slot == `SLOT_LAST);
   assign next_tx_slot = tx_word_take ? 3'h0 : tx_slot + 3'h1;

   function [2:0] ones6;
      input [5:0] v;
      begin
         ones6 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]}
               + {2'h0, v[3]} + {2'h0, v[4]} + {2'h0, v[5]};
      end
   endfunction

   // Lanes are a loop so that wider links only widen the loop.
   // RULE8: replicable lane slice
   genvar l;
   generate
      for (l = 0; l < `LANES; l = l + 1) begin : g_tx
         wire [2:0] ones;
         wire       bal;
         assign ones = ones6(tx_word[l*6 +: 6]);
         // RULE6: balance bit polarity
         // RULE7: tie gives zero
         assign bal = (ones < `BAL_HALF);
         // RULE5: 24 payload plus balance
         assign tx_fmt[l*7 +: 7] = tx_balance_en ? {bal, tx_word[l*6 +: 6]}
                                                 : tx_word[l*7 +: 7];
      end
   endgenerate

   // RULE17: one lane bit per cycle
   always @(posedge core_clk) begin
      if (!rstn) begin
         tx_lane <= 4'h0;
      end else begin
         for (tl = 0; tl < `LANES; tl = tl + 1) begin
            if (tx_word_take) begin
               tx_lane[tl] <= tx_fmt[tl*7];
            end else begin
               tx_lane[tl] <= tx_hold[tl*7 + next_tx_slot];
            end
         end
      end
   end

   always @(posedge core_clk) begin
      if (!rstn) begin
         tx_slot    <= 3'h0;
         tx_hold    <= 28'h0000000;
         tx_fwd_clk <= 1'b0;
         tx_run     <= 1'b0;
      end else begin
         // RULE2: bit clock shifts data
         tx_slot <= next_tx_slot;
         if (tx_word_take) begin
            tx_hold <= tx_fmt;
            tx_run  <= 1'b1;
         end
         // Holding the clock low until the first word keeps a short false
         // frame off the link just after reset.
         // RULE3: one period per symbol
         // RULE4: rise on first nibble
         tx_fwd_clk <= (tx_word_take || tx_run) && (next_tx_slot < `FWD_HIGH_SLOTS);
      end
   end

   // ======================================================================
   // Receive capture and phase dial
   reg  [3:0]  rx_lane_s1;
   reg  [3:0]  rx_lane_s2;
   reg         rx_fwd_s1;
   reg         rx_fwd_s2;
   reg         rx_fwd_prev;
   reg  [27:0] rx_dline;
   wire [31:0] rx_taps;
   wire [3:0]  rx_sample;
   wire        rx_edge;

   always @(posedge core_clk) begin
      if (!rstn) begin
         rx_lane_s1  <= 4'h0;
         rx_lane_s2  <= 4'h0;
         rx_fwd_s1   <= 1'b0;
         rx_fwd_s2   <= 1'b0;
         rx_fwd_prev <= 1'b0;
         rx_dline    <= 28'h0000000;
      end else begin
         // RULE19: one sample per bit edge
         rx_lane_s1  <= rx_lane;
         rx_lane_s2  <= rx_lane_s1;
         rx_fwd_s1   <= rx_fwd_clk;
         rx_fwd_s2   <= rx_fwd_s1;
         rx_fwd_prev <= rx_fwd_s2;
         rx_dline    <= rx_taps[27:0];
      end
   end

   // Delaying data against the clock moves the sampling point earlier; the
   // dial only steps whole bits, so fine eye centring stays at the board.
   assign rx_taps = {rx_dline, rx_lane_s2};
   // RULE11: shifted sampling point
   assign rx_sample = rx_taps[rx_shift_tap*4 +: 4];
   assign rx_edge = rx_fwd_s2 & ~rx_fwd_prev;

   always @(posedge core_clk) begin
      if (!rstn) begin
         rx_shift_tap <= 3'h0;
      end else if (!rx_shift_mode) begin
         // RULE15: constant shift mode
         rx_shift_tap <= rx_shift_const;
      end else if (rx_shift_step) begin
         // RULE15: variable shift steps
         if (rx_shift_up && rx_shift_tap != `TAP_MAX) begin
            rx_shift_tap <= rx_shift_tap + 3'h1;
         end else if (!rx_shift_up && rx_shift_tap != 3'h0) begin
            rx_shift_tap <= rx_shift_tap - 3'h1;
         end
      end
   end

   // ======================================================================
   // Receive framing
   reg  [2:0]  rx_slot;
   reg  [27:0] rx_acc;
   wire [27:0] rx_word;
   wire        rx_wr;
   integer     rl;

   // RULE18: lanes combine for wider links
   generate
      for (l = 0; l < `LANES; l = l + 1) begin : g_rx
         // RULE12: same bit pattern
         assign rx_word[l*7 +: 7] = {rx_sample[l], rx_acc[l*7 +: 6]};
      end
   endgenerate

   always @(posedge core_clk) begin
      if (!rstn) begin
         rx_acc <= 28'h0000000;
      end else begin
         for (rl = 0; rl < `LANES; rl = rl + 1) begin
            if (rx_edge) begin
               rx_acc[rl*7] <= rx_sample[rl];
            end else if (rx_slot < `SLOT_LAST) begin
               rx_acc[rl*7 + rx_slot] <= rx_sample[rl];
            end
         end
      end
   end

   // RULE21: one write per period
   assign rx_wr = rx_aligned && !rx_edge && (rx_slot == `SLOT_LAST);

   always @(posedge core_clk) begin
      if (!rstn) begin
         rx_slot    <= `SLOT_IDLE;
         rx_aligned <= 1'b0;
      end else if (rx_edge) begin
         // RULE10: edge frames bit zero
         rx_slot    <= 3'h1;
         rx_aligned <= 1'b1;
      end else if (rx_slot != `SLOT_IDLE) begin
         // A stopped clock parks the framer idle instead of wrapping.
         rx_slot <= rx_slot + 3'h1;
      end
   end

   // ======================================================================
   // Receive FIFO
   reg  [27:0] fifo_mem [0:`FIFO_DEPTH-1];
   reg  [4:0]  wptr;
   reg  [4:0]  rptr;
   wire [4:0]  fill;
   wire        rd_go;

   assign fill  = wptr - rptr;
   assign rx_empty = (fill == 5'h00);
   assign rx_full  = (fill == `FIFO_FULL);
   // RULE20: fill level flags
   assign rx_quarter       = (fill >= `FIFO_QUARTER);
   assign rx_half          = (fill >= `FIFO_HALF);
   assign rx_three_quarter = (fill >= `FIFO_3QUARTER);
   assign rd_go = rx_rd_en && !rx_empty;

   always @(posedge core_clk) begin
      if (rx_wr && !rx_full) begin
         fifo_mem[wptr[`FIFO_AW-1:0]] <= rx_word;
      end
   end

   always @(posedge core_clk) begin
      if (!rstn) begin
         wptr        <= 5'h00;
         rptr        <= 5'h00;
         rx_rd_data  <= 28'h0000000;
         rx_rd_valid <= 1'b0;
         rx_overflow <= 1'b0;
      end else begin
         rx_rd_valid <= rd_go;
         // RULE9: words into FIFO
         if (rx_wr && !rx_full) begin
            wptr <= wptr + 5'h01;
         end
         // Dropping the new word keeps older words in order; sticky flag.
         if (rx_wr && rx_full) begin
            rx_overflow <= 1'b1;
         end
         if (rd_go) begin
            rx_rd_data <= fifo_mem[rptr[`FIFO_AW-1:0]];
            rptr       <= rptr + 5'h01;
         end
      end
   end

endmodule // serdes_7to1_forwarded_clock

`default_nettype wire

/* sim/serdes_props.sv */
// Checker on the ports of the serial slice.
// Assumes core_clk is the bit clock and rstn a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module serdes_props (
   input wire logic        core_clk,
   input wire logic        rstn,
   input wire logic [27:0] tx_word,
   input wire logic        tx_balance_en,
   input wire logic        tx_word_take,
   input wire logic [3:0]  tx_lane,
   input wire logic        tx_fwd_clk,
   input wire logic        rx_rd_en,
   input wire logic        rx_rd_valid,
   input wire logic        rx_empty,
   input wire logic        rx_quarter,
   input wire logic        rx_half,
   input wire logic        rx_three_quarter,
   input wire logic        rx_full,
   input wire logic        rx_overflow,
   input wire logic        rx_aligned,
   input wire logic        rx_shift_mode,
   input wire logic [2:0]  rx_shift_const,
   input wire logic        rx_shift_step,
   input wire logic [2:0]  rx_shift_tap
);
   wire [3:0] slot0_bits = {tx_word[21], tx_word[14], tx_word[7], tx_word[0]};
   wire [5:0] lane0_pay  = tx_word[5:0];
   // ======
   // Framing, FIFO and phase dial checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence fwd_hi;
      tx_fwd_clk [*4];
   endsequence
   sequence fwd_lo;
      !tx_fwd_clk [*3];
   endsequence
   a_take_period:
      assert property (tx_word_take |=> !tx_word_take [*6] ##1 tx_word_take) else $error("take gap");
   a_fwd_frame:
      assert property (tx_word_take |=> $rose(tx_fwd_clk)) else $error("fwd not framed");
   a_fwd_shape:
      assert property ($rose(tx_fwd_clk) |-> fwd_hi ##1 fwd_lo) else $error("fwd shape");
   a_plain_slot0:
      assert property (tx_word_take && !tx_balance_en |=> tx_lane == $past(slot0_bits))
         else $error("slot0 bits");
   a_bal_bit:
      assert property (tx_word_take && tx_balance_en |-> ##7
         tx_lane[0] == ($countones($past(lane0_pay, 7)) < 3)) else $error("balance bit");
   a_rd_valid:
      assert property (rx_rd_en && !rx_empty |=> rx_rd_valid) else $error("no valid");
   a_rd_empty:
      assert property (rx_rd_en && rx_empty |=> !rx_rd_valid) else $error("valid on empty");
   a_flag_order:
      assert property (rx_full |-> rx_three_quarter && rx_half && rx_quarter && !rx_empty)
         else $error("fill flags");
   a_ovf_cause:
      assert property ($rose(rx_overflow) |-> $past(rx_full)) else $error("overflow cause");
   a_ovf_sticky:
      assert property (rx_overflow |=> rx_overflow) else $error("overflow dropped");
   a_tap_const:
      assert property (!rx_shift_mode |=> rx_shift_tap == $past(rx_shift_const))
         else $error("tap not constant");
   a_tap_idle:
      assert property (rx_shift_mode && !rx_shift_step |=> $stable(rx_shift_tap))
         else $error("tap moved");
   a_align_stay:
      assert property (rx_aligned |=> rx_aligned) else $error("alignment lost");
endmodule // serdes_props
bind serdes_7to1_forwarded_clock serdes_props props_u (.core_clk, .rstn, .tx_word,
   .tx_balance_en, .tx_word_take, .tx_lane, .tx_fwd_clk, .rx_rd_en, .rx_rd_valid, .rx_empty,
   .rx_quarter, .rx_half, .rx_three_quarter, .rx_full, .rx_overflow, .rx_aligned,
   .rx_shift_mode, .rx_shift_const, .rx_shift_step, .rx_shift_tap);
`default_nettype wire

/* sim/remote_ser.sv */
// Far-end serializer feeding the receive lanes and forwarded clock.
// Assumes the bench offers a word whenever take is high.
`timescale 1ns/1ps
`default_nettype none
module remote_ser (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic        run,
   input  wire logic [27:0] word,
   output wire logic        take,
   output var  logic [3:0]  lane,
   output var  logic        fwd
);
   logic [2:0]  slot;
   logic [27:0] cur;
   wire  [2:0]  ns  = (slot == 3'h6) ? 3'h0 : slot + 3'h1;
   wire  [27:0] src = take ? word : cur;
   assign take = run && slot == 3'h6;
   // ======
   // symbol framing
   always @(posedge core_clk) begin
      if (!rstn || !run) begin
         slot <= 3'h6;
         fwd  <= 1'b0;
         // Idle lanes flip so no stale bit looks valid.
         lane <= rstn ? ~lane : 4'h0;
      end else begin
         slot <= ns;
         cur  <= src;
         fwd  <= ns < 3'h4;
         for (int l = 0; l < 4; l++)
            lane[l] <= src[l*7+ns];
      end
   end
endmodule // remote_ser
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench: transmit framing, then receive into the FIFO.
// Assumes a 25 MHz core_clk and the remote_ser far-end model.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        core_clk = 1'b0;
   logic        rstn = 1'b0;
   logic [27:0] tx_word = 28'h0;
   logic        tx_balance_en = 1'b0;
   logic        rx_rd_en = 1'b0;
   logic        rx_shift_mode = 1'b0;
   logic [2:0]  rx_shift_const = 3'h0;
   logic        rx_shift_step = 1'b0;
   logic        rx_shift_up = 1'b0;
   logic [2:0]  rx_shift_tap;
   logic        p_run = 1'b0;
   logic [27:0] p_word = 28'hfffffff;
   logic [31:0] seed = 32'h46;
   logic [27:0] q[$];
   int          num_errors = 0;
   int          n_tests = 0;
   int          i, n;
   logic [31:0] r;
   logic        tx_word_take, tx_fwd_clk, p_take, p_fwd;
   logic        rx_rd_valid, rx_empty, rx_full, rx_quarter, rx_half;
   logic        rx_three_quarter, rx_overflow, rx_aligned;
   logic [3:0]  tx_lane, p_lane;
   logic [27:0] rx_rd_data;
   always #20 core_clk = ~core_clk;
   remote_ser far_u (.core_clk, .rstn, .run(p_run), .word(p_word), .take(p_take),
      .lane(p_lane), .fwd(p_fwd));
   serdes_7to1_forwarded_clock dut_u (.core_clk, .rstn, .tx_word, .tx_balance_en,
      .tx_word_take, .tx_lane, .tx_fwd_clk, .rx_lane(p_lane), .rx_fwd_clk(p_fwd),
      .rx_shift_mode, .rx_shift_const, .rx_shift_step, .rx_shift_up,
      .rx_shift_tap, .rx_aligned, .rx_rd_en, .rx_rd_data, .rx_rd_valid, .rx_empty,
      .rx_full, .rx_quarter, .rx_half, .rx_three_quarter, .rx_overflow);
   // ======
   // Helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [3:0] exp_lanes(input logic [27:0] w, input logic b, input int k);
      logic [3:0] e;
      for (int l = 0; l < 4; l++)
         e[l] = !b ? w[l*7+k] : (k < 6 ? w[l*6+k] : ($countones(w[l*6+:6]) < 3));
      return e;
   endfunction
   task automatic check(input logic [27:0] got, input logic [27:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("tests %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic tx_one(input logic [27:0] w, input logic b);
      int j;
      @(posedge core_clk);
      tx_word <= w;
      tx_balance_en <= b;
      for (j = 0; j < 9; j++) begin
         @(negedge core_clk);
         if (tx_word_take === 1'b1) break;
      end
      if (j == 9) begin
         num_errors++;
         end_sim();
      end
      for (j = 0; j < 7; j++) begin
         @(negedge core_clk);
         check(28'({tx_fwd_clk, tx_lane}), 28'({j < 4, exp_lanes(w, b, j)}));
      end
   endtask
   task automatic dial(input logic up, input int k, input logic [2:0] exp);
      repeat (k) begin
         @(posedge core_clk);
         rx_shift_step <= 1'b1;
         rx_shift_up <= up;
         @(posedge core_clk);
         rx_shift_step <= 1'b0;
      end
      @(posedge core_clk);
      @(negedge core_clk);
      check(28'(rx_shift_tap), 28'(exp));
   endtask
   // Words are counted as the far end latches them.
   always @(posedge core_clk)
      if (p_take) begin
         q.push_back(p_word);
         p_word <= rnd();
      end
   // ======
   // Main sequence
   initial begin
      repeat (12) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      rx_shift_mode <= 1'b1;
      dial(1'b1, 9, 3'h7);
      dial(1'b0, 3, 3'h4);
      dial(1'b0, 6, 3'h0);
      @(posedge core_clk);
      rx_shift_mode <= 1'b0;
      rx_shift_const <= 3'h5;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      check(28'(rx_shift_tap), 28'h5);
      @(posedge core_clk);
      rx_shift_const <= 3'h0;
      $display("tap test done");
      tx_one(28'hfffffff, 1'b0);
      tx_one(28'h0, 1'b1);
      tx_one(28'hfffffff, 1'b1);
      tx_one(28'h1c71c7, 1'b1);
      repeat (6) begin
         r = rnd();
         tx_one(r[27:0], r[31]);
      end
      $display("tx test done");
      @(posedge core_clk);
      p_run <= 1'b1;
      // Overfill on purpose: more words than the FIFO holds.
      for (i = 0; i < 200 && q.size() < 18; i++) @(negedge core_clk);
      if (q.size() < 18) num_errors++;
      @(posedge core_clk);
      p_run <= 1'b0;
      repeat (12) @(posedge core_clk);
      check(28'({rx_aligned, rx_overflow, rx_full}), 28'h7);
      rx_rd_en <= 1'b1;
      n = 0;
      for (i = 0; i < 40 && n < 16; i++) begin
         @(negedge core_clk);
         if (rx_rd_valid === 1'b1) begin
            check(rx_rd_data, q[n]);
            n++;
            check(28'({rx_empty, rx_quarter, rx_half, rx_three_quarter}),
               28'({n == 16, 16 - n >= 4, 16 - n >= 8, 16 - n >= 12}));
         end
      end
      if (n < 16) num_errors++;
      @(negedge core_clk);
      check(28'(rx_rd_valid), 28'h0);
      @(posedge core_clk);
      rx_rd_en <= 1'b0;
      $display("rx test done");
      end_sim();
   end
endmodule // tb
`default_nettype wire
